// ===== core/qstb_top.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "qstb_regs.svh"

module qstb_top
  import qstb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // reference clock pins
  input  wire logic        oscillatorOutputClock,
  input  wire logic        lowPower1khzOscillator,
  input  wire logic        internalReferenceClock,
  // lite bus write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // lite bus write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // lite bus write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // lite bus read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // lite bus read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // block outputs
  output logic             tickClockOutput,
  output logic             matchPulseOut,
  output logic             irqReq
);

  qstb_state_t s_q;  // registered state
  qstb_state_t s_d;  // next state

  // predivide ratio from fast input to tick clock
  function automatic logic [8:0] preDiv(input logic [2:0] ps);
    case (ps)
      3'h4:    preDiv = 9'h080;  // 4.9152 MHz to 38.4 kHz
      3'h5:    preDiv = 9'h07D;  // 4 MHz to 32 kHz
      3'h6:    preDiv = 9'h0FA;  // 8 MHz to 32 kHz
      3'h7:    preDiv = 9'h1F4;  // 16 MHz to 32 kHz
      default: preDiv = 9'h001;  // tick clock equals input
    endcase
  endfunction

  // divide ratio from tick clock to 4 Hz
  function automatic logic [13:0] secDiv(input logic [2:0] ps);
    case (ps)
      3'h0:          secDiv = 14'h00FA;  // 1 kHz
      3'h1:          secDiv = 14'h2000;  // 32.768 kHz
      3'h3, 3'h4:    secDiv = 14'h2580;  // 38.4 kHz
      default:       secDiv = 14'h1F40;  // 32 kHz
    endcase
  endfunction

  // read mux, returns ok flag above data byte
  function automatic logic [8:0] regRead(input qstb_state_t st, input logic [7:0] addr);
    case (addr)
      `QSTB_OFF_CTRL:  regRead = {1'b1, st.enable, st.clkSel, 1'b0, st.clkOutEn, st.prescale};
      `QSTB_OFF_STAT:  regRead = {1'b1, st.qsFlag, st.secFlag, st.mFlag, st.qsIe, st.one_second_irq_enable, st.mIe,
                                  st.mEn, (st.mwpCnt != 2'h0)};
      `QSTB_OFF_MATCH: regRead = {1'b1, st.matchVal, st.matchSub};
      `QSTB_OFF_COUNT: regRead = {1'b1, st.count};
      default:         regRead = 9'h000;
    endcase
  endfunction

  logic       srcLvl;     // selected filtered reference level
  logic       srcEdge;    // rising edge of selected reference
  logic       tickPulse;  // one tick clock period elapsed
  logic       qsTick;     // 4 Hz tick
  logic [7:0] cntInc;     // counter after increment
  logic       matchHit;   // match condition this cycle
  logic       wrGo;       // register write performed
  logic       wrCtrl;     // write hits control
  logic       wrStat;     // write hits status
  logic       wrMatch;    // write hits match
  logic       wrOk;       // write address mapped
  logic [8:0] rdWord;     // read mux result
  logic [8:0] wrWord;     // write address decode result
  logic [8:0] preN;       // active predivide ratio
  logic [13:0] secN;      // active 4 Hz ratio

  // next state of the whole block
  always_comb begin
    s_d = s_q;

    // three-stage sampling, change taken when stages two and three agree
    s_d.sync1 = {internalReferenceClock, lowPower1khzOscillator, oscillatorOutputClock};
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    for (int i = 0; i < 3; i++) begin
      if (s_q.sync2[i] == s_q.sync3[i]) begin
        s_d.refLvl[i] = s_q.sync3[i];
      end
    end

    // reference select, reserved code gives no edges
    case (s_q.clkSel)
      QSTB_SRC_OSC:  srcLvl = s_q.refLvl[0];
      QSTB_SRC_LPO:  srcLvl = s_q.refLvl[1];
      QSTB_SRC_IREF: srcLvl = s_q.refLvl[2];
      default:       srcLvl = 1'b0;
    endcase
    case (s_q.clkSel)
      QSTB_SRC_OSC:  srcEdge = s_d.refLvl[0] & ~s_q.refLvl[0];
      QSTB_SRC_LPO:  srcEdge = s_d.refLvl[1] & ~s_q.refLvl[1];
      QSTB_SRC_IREF: srcEdge = s_d.refLvl[2] & ~s_q.refLvl[2];
      default:       srcEdge = 1'b0;
    endcase

    preN = preDiv(s_q.prescale);
    secN = secDiv(s_q.prescale);

    // predivider runs when counting or when the tick clock is wanted
    tickPulse = 1'b0;
    if (s_q.enable | s_q.clkOutEn) begin
      if (srcEdge) begin
        if (s_q.preCnt >= preN - 9'h001) begin
          s_d.preCnt = 9'h000;
          tickPulse  = 1'b1;
        end else begin
          s_d.preCnt = s_q.preCnt + 9'h001;
        end
      end
    end else begin
      s_d.preCnt = 9'h000;
    end

    // tick clock output, gated by its enable
    if (!s_q.clkOutEn) begin
      s_d.tickClk = 1'b0;
    end else if (preN == 9'h001) begin
      s_d.tickClk = srcLvl;
    end else begin
      s_d.tickClk = (s_q.preCnt < (preN >> 1));
    end

    // 4 Hz generator
    qsTick = 1'b0;
    if (tickPulse) begin
      if (s_q.divCnt >= secN - 14'h0001) begin
        s_d.divCnt = 14'h0000;
        qsTick     = s_q.enable;
      end else begin
        s_d.divCnt = s_q.divCnt + 14'h0001;
      end
    end

    // counter advance and match
    cntInc   = s_q.count + 8'h01;
    matchHit = qsTick & s_q.mEn & (cntInc[7:2] == s_q.matchVal);
    s_d.matchPulse = matchHit;
    if (qsTick) begin
      s_d.count = matchHit ? {6'h00, cntInc[1:0]} : cntInc;
    end

    // match write pending countdown
    if (s_q.mwpCnt != 2'h0) begin
      s_d.mwpCnt = s_q.mwpCnt - 2'h1;
    end

    // bus write channel capture, either order
    if (!s_q.awHeld && s_axi_awvalid) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (!s_q.wHeld && s_axi_wvalid) begin
      s_d.wHeld  = 1'b1;
      s_d.wData  = s_axi_wdata[7:0];
      s_d.wStrb0 = s_axi_wstrb[0];
    end

    // perform write once both halves are held
    wrGo    = s_q.awHeld & s_q.wHeld & ~s_q.bvalid;
    wrWord  = regRead(s_q, s_q.awAddr);  // top bit marks a mapped offset
    wrOk    = wrWord[8];
    wrCtrl  = wrGo & s_q.wStrb0 & (s_q.awAddr == `QSTB_OFF_CTRL);
    wrStat  = wrGo & s_q.wStrb0 & (s_q.awAddr == `QSTB_OFF_STAT);
    wrMatch = wrGo & s_q.wStrb0 & (s_q.awAddr == `QSTB_OFF_MATCH);
    if (wrGo) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = wrOk ? `QSTB_RESP_OKAY : `QSTB_RESP_SLVERR;
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // control register write
    if (wrCtrl) begin
      s_d.enable   = s_q.wData[`QSTB_CTRL_EN_BIT];
      s_d.clkSel   = qstb_src_t'(s_q.wData[`QSTB_CTRL_SRC_HI:`QSTB_CTRL_SRC_LO]);
      s_d.clkOutEn = s_q.wData[`QSTB_CTRL_CKOE_BIT];
      s_d.prescale = s_q.wData[`QSTB_CTRL_PS_HI:`QSTB_CTRL_PS_LO];
    end

    // status register write, hardware set wins over write-one clear
    s_d.qsFlag  = (s_q.qsFlag & ~(wrStat & s_q.wData[`QSTB_STAT_QSF_BIT])) | qsTick;
    s_d.secFlag = (s_q.secFlag & ~(wrStat & s_q.wData[`QSTB_STAT_SF_BIT]))
                  | (qsTick & (cntInc[1:0] == 2'h0));
    s_d.mFlag   = (s_q.mFlag & ~(wrStat & s_q.wData[`QSTB_STAT_MF_BIT])) | matchHit;
    if (wrStat) begin
      s_d.qsIe  = s_q.wData[`QSTB_STAT_QSIE_BIT];
      s_d.one_second_irq_enable = s_q.wData[`QSTB_STAT_SIE_BIT];
      s_d.mIe   = s_q.wData[`QSTB_STAT_MIE_BIT];
      s_d.mEn   = s_q.wData[`QSTB_STAT_MEN_BIT];
    end

    // match register write copies low counter bits
    if (wrMatch) begin
      s_d.matchVal = s_q.wData[7:2];
      s_d.matchSub = s_d.count[1:0];
      s_d.mwpCnt   = `QSTB_MWP_CYC;
    end

    // clear on disable or on clear bit write
    if (!s_q.enable || (wrCtrl && s_q.wData[`QSTB_CTRL_CLR_BIT])) begin
      s_d.count  = `QSTB_RST_COUNT;
      s_d.divCnt = 14'h0000;
    end

    // interrupt request from flags and enables
    s_d.irq = (s_d.qsFlag & s_d.qsIe) | (s_d.secFlag & s_d.one_second_irq_enable) | (s_d.mFlag & s_d.mIe);

    // read channel
    rdWord = regRead(s_q, s_axi_araddr);
    if (!s_q.rvalid && s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = {24'h00_0000, rdWord[7:0]};
      s_d.rresp  = rdWord[8] ? `QSTB_RESP_OKAY : `QSTB_RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q          <= '0;
      s_q.clkSel   <= QSTB_SRC_OSC;
      s_q.prescale <= `QSTB_RST_PS;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign s_axi_awready  = ~s_q.awHeld;
  assign s_axi_wready   = ~s_q.wHeld;
  assign s_axi_bvalid   = s_q.bvalid;
  assign s_axi_bresp    = s_q.bresp;
  assign s_axi_arready  = ~s_q.rvalid;
  assign s_axi_rvalid   = s_q.rvalid;
  assign s_axi_rdata    = s_q.rdata;
  assign s_axi_rresp    = s_q.rresp;
  assign tickClockOutput = s_q.tickClk;
  assign matchPulseOut  = s_q.matchPulse;
  assign irqReq         = s_q.irq;

endmodule

// ===== inc/qstb_pkg.sv
package qstb_pkg;

  // reference clock source codes
  typedef enum logic [1:0] {
    QSTB_SRC_OSC  = 2'h0,
    QSTB_SRC_LPO  = 2'h1,
    QSTB_SRC_IREF = 2'h2,
    QSTB_SRC_RSVD = 2'h3
  } qstb_src_t;

  // whole state of the block
  typedef struct packed {
    logic [2:0]  sync1;       // first stage per reference pin
    logic [2:0]  sync2;       // second stage
    logic [2:0]  sync3;       // third stage
    logic [2:0]  refLvl;      // filtered reference levels
    logic [8:0]  preCnt;      // predivider count
    logic [13:0] divCnt;      // 4 Hz divider count
    logic        enable;      // module enable
    qstb_src_t   clkSel;      // reference select
    logic        clkOutEn;    // tick clock output enable
    logic [2:0]  prescale;    // prescale select
    logic        qsFlag;      // quarter-second flag
    logic        secFlag;     // one-second flag
    logic        mFlag;       // match flag
    logic        qsIe;        // quarter-second irq enable
    logic        one_second_irq_enable;       // one-second irq enable
    logic        mIe;         // match irq enable
    logic        mEn;         // match function enable
    logic [1:0]  mwpCnt;      // match write pending count
    logic [7:0]  count;       // quarter-second counter
    logic [5:0]  matchVal;    // match value
    logic [1:0]  matchSub;    // copied low counter bits
    logic        tickClk;     // tick clock output
    logic        matchPulse;  // match pulse output
    logic        irq;         // interrupt request
    logic        awHeld;      // write address captured
    logic [7:0]  awAddr;      // captured write address
    logic        wHeld;       // write data captured
    logic [7:0]  wData;       // captured low data byte
    logic        wStrb0;      // captured low lane strobe
    logic        bvalid;      // write response valid
    logic [1:0]  bresp;       // write response code
    logic        rvalid;      // read response valid
    logic [31:0] rdata;       // read data
    logic [1:0]  rresp;       // read response code
  } qstb_state_t;

endpackage

// ===== inc/qstb_regs.svh
`ifndef QSTB_REGS_SVH
`define QSTB_REGS_SVH

// register byte offsets on the lite bus
`define QSTB_OFF_CTRL        8'h00
`define QSTB_OFF_STAT        8'h04
`define QSTB_OFF_MATCH       8'h08
`define QSTB_OFF_COUNT       8'h0C

// control register field positions
`define QSTB_CTRL_EN_BIT     7
`define QSTB_CTRL_SRC_HI     6
`define QSTB_CTRL_SRC_LO     5
`define QSTB_CTRL_CLR_BIT    4
`define QSTB_CTRL_CKOE_BIT   3
`define QSTB_CTRL_PS_HI      2
`define QSTB_CTRL_PS_LO      0

// status register field positions
`define QSTB_STAT_QSF_BIT    7
`define QSTB_STAT_SF_BIT     6
`define QSTB_STAT_MF_BIT     5
`define QSTB_STAT_QSIE_BIT   4
`define QSTB_STAT_SIE_BIT    3
`define QSTB_STAT_MIE_BIT    2
`define QSTB_STAT_MEN_BIT    1
`define QSTB_STAT_MWP_BIT    0

// reset values
`define QSTB_RST_SRC         2'h0
`define QSTB_RST_PS          3'h1
`define QSTB_RST_COUNT       8'h00

// timing counts
`define QSTB_MWP_CYC         2'h2

// bus response codes
`define QSTB_RESP_OKAY       2'h0
`define QSTB_RESP_SLVERR     2'h2

`endif

// ===== tb/qstb_chk.sv
`timescale 1ns/100ps

// port-level timing checks of the time base
module qstb_chk
  import qstb_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // lite bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // block outputs
  input wire logic        tickClockOutput,
  input wire logic        matchPulseOut,
  input wire logic        irqReq
);
  // one clock domain, quiet during reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  AST_PULSE_ONE: assert property (matchPulseOut |=> !matchPulseOut)
    else $error("match pulse wider than one cycle");
  AST_RST_OUT: assert property (disable iff (1'b0) srst |=> !matchPulseOut && !irqReq && !tickClockOutput)
    else $error("outputs not idle after reset");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  AST_WR_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_RV_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  AST_BV_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  // main scenarios reached
  COV_PULSE: cover property (matchPulseOut);
  COV_IRQ: cover property ($rose(irqReq));
  COV_TICK: cover property ($rose(tickClockOutput));
endmodule

// ===== tb/quarter_second_time_base_test.sv
`timescale 1ns/100ps
`include "qstb_regs.svh"

// attach the port checker to the top
bind qstb_top qstb_chk qstb_chk_inst (.mclk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tickClockOutput, .matchPulseOut, .irqReq);

module quarter_second_time_base_test;
  // register addresses
  localparam logic [7:0] adCt = `QSTB_OFF_CTRL, adSt = `QSTB_OFF_STAT;
  localparam logic [7:0] adMa = `QSTB_OFF_MATCH, adCn = `QSTB_OFF_COUNT;
  // clock, reset, reference pin
  logic        mclk = 1'b0, srst = 1'b1, refClk = 1'b0;
  // which reference pin toggles, 3 lets all of them toggle
  logic [1:0]  pinSel = 2'h3;
  // master side of the bus
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  // design outputs
  logic        awready, wready, bvalid, arready, rvalid, tickOut, matchOut, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  // notes of expected answers
  logic [65:0] rq[$], note;
  logic [1:0]  bq[$];
  int          numErrors = 0, numChecks = 0, seed = 15802, tickRise = 0, n0;

  qstb_top qstb_top_inst (.mclk(mclk), .srst(srst),
    .oscillatorOutputClock(refClk & (pinSel == 2'h0 || pinSel == 2'h3)),
    .lowPower1khzOscillator(refClk & (pinSel == 2'h1 || pinSel == 2'h3)),
    .internalReferenceClock(refClk & (pinSel == 2'h2 || pinSel == 2'h3)),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .tickClockOutput(tickOut), .matchPulseOut(matchOut), .irqReq(irq));

  // bus clock and a slow reference, each level held three cycles
  always #4 mclk = ~mclk;
  always begin
    repeat (3) @(posedge mclk);
    refClk <= ~refClk;
  end
  always @(posedge tickOut) tickRise++;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    numChecks++;
    if (s !== e) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // one write, address and data offered together, random upper bits
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = `QSTB_RESP_OKAY);
    logic [31:0] x;
    logic ta, tw, tb;
    @(posedge mclk);  // launch just after a rising edge
    x = $random(seed);
    bq.push_back(r);
    awaddr <= a;
    wdata <= {x[31:8], v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge mclk);
      x = $random(seed);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= !tb && (bready | x[0]);
    end while (!tb);
  endtask

  // one read, ready raised after a random delay
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic [1:0] r = `QSTB_RESP_OKAY);
    logic [31:0] x;
    logic ta, tr;
    @(posedge mclk);  // launch just after a rising edge
    rq.push_back({m, e, r});
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge mclk);
      x = $random(seed);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      rready <= !tr && (rready | x[0]);
    end while (!tr);
  endtask

  // poll the counter until it shows the given value
  task automatic waitCnt(input logic [7:0] t);
    d = 32'hFFFF_FFFF;
    for (int i = 0; i < 3000 && d[7:0] !== t; i++) rd(adCn, 0, 0);
    chk("waitCnt", {24'h00_0000, t}, {24'h00_0000, d[7:0]});
  endtask

  task automatic printVerdict();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // answers are compared with the oldest note the cycle they are taken
  always @(negedge mclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      note = rq.pop_front();
      chk("rdata", note[33:2] & note[65:34], rdata & note[65:34]);
      chk("rresp", {30'h0, note[1:0]}, {30'h0, rresp});
    end
    if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    numErrors++;
    printVerdict();
  end

  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    // reset values, then an unmapped place
    for (int i = 0; i < 5; i++) rd(8'(i * 4), {31'h0, i == 0}, '1, (i == 4) ? 2'h2 : 2'h0);
    wr(8'h10, 8'hFF, `QSTB_RESP_SLVERR);
    rd(adCt, 32'h0000_0001);
    // each reference source, set while disabled, counter cleared on enable
    for (int s = 0; s < 4; s++) begin
      pinSel <= 2'(s);
      wr(adCt, {1'b0, 2'(s - 1), 5'h08});
      wr(adCt, {1'b0, 2'(s), 5'h08});
      wr(adCt, {1'b1, 2'(s), 5'h18});
      rd(adCt, {24'h0, 1'b1, 2'(s), 5'h08});
      n0 = tickRise;
      repeat (2000) @(posedge mclk);
      rd(adCn, (s == 3) ? 0 : 1);
      chk("tickRuns", {31'h0, s < 3}, {31'h0, tickRise > n0});
    end
    wr(adCt, 8'h60);
    wr(adCt, 8'h20);
    wr(adCt, 8'hB0);
    n0 = tickRise;
    wr(adSt, 8'hE8);
    waitCnt(8'h01);
    @(negedge mclk);
    chk("tickOff", 32'h0000_0002, {30'h0, tickRise == n0, tickOut});
    chk("irqMasked", 32'h0000_0000, {31'h0, irq});
    rd(adSt, 32'h0000_0088);
    wr(adSt, 8'h18);
    repeat (3) @(negedge mclk);
    chk("irqQs", 32'h0000_0001, {31'h0, irq});
    wr(adSt, 8'h88);
    repeat (3) @(negedge mclk);
    chk("irqClr", 32'h0000_0000, {31'h0, irq});
    rd(adSt, 32'h0000_0008);
    waitCnt(8'h04);
    rd(adSt, 32'h0000_00C8);
    chk("irqSec", 32'h0000_0001, {31'h0, irq});
    wr(adSt, 8'hC0);
    repeat (3) @(negedge mclk);
    chk("irqSecOff", 32'h0000_0000, {31'h0, irq});
    // match at count 8, interrupt masked first; pending bit read while the write settles
    fork
      wr(adMa, 8'h08);
      begin
        repeat (2) @(posedge mclk);
        rd(adSt, 32'h0000_0001, 32'h0000_0001);
      end
    join
    rd(adMa, 32'h0000_0008);
    rd(adSt, 32'h0000_0000, 32'h0000_0001);
    wr(adSt, 8'h02);
    for (int i = 0; i < 9000 && matchOut !== 1'b1; i++) @(negedge mclk);
    chk("pulse", 32'h0000_0001, {31'h0, matchOut});
    @(negedge mclk);
    chk("pulseEnd", 32'h0000_0000, {31'h0, matchOut});
    rd(adCn, 0);
    rd(adSt, 32'h0000_00A2, 32'hFFFF_FFBF);
    chk("irqNoMie", 32'h0000_0000, {31'h0, irq});
    wr(adSt, 8'h06);
    repeat (3) @(negedge mclk);
    chk("irqMatch", 32'h0000_0001, {31'h0, irq});
    wr(adSt, 8'hE0);
    repeat (3) @(negedge mclk);
    chk("irqMatchClr", 32'h0000_0000, {31'h0, irq});
    // disabling holds the counter at zero
    waitCnt(8'h02);
    wr(adCt, 8'h20);
    rd(adCn, 0);
    repeat (1600) @(posedge mclk);
    rd(adCn, 0);
    printVerdict();
  end
endmodule
